// [hw/isl_input_stage.sv]
// input stage load, pointer advance and write-check compare
`timescale 1ns/1ps
module isl_input_stage
   import isl_pkg::*;
#(
   parameter int W = DATA_W
) (
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic [3:0] WB_ADR_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic WB_WE_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   output logic WB_ACK_OUT,
   input wire logic DRIVE_SYNC_CLK_IN,
   input wire logic [W-1:0] DRIVE_DATA_IN,
   input wire logic [W-1:0] SELECT_MUX_EVEN_IN,
   input wire logic [W-1:0] SELECT_MUX_ODD_IN,
   input wire logic EVEN_HALF_FULL_IN,
   input wire logic ODD_HALF_FULL_IN,
   input wire logic [W-1:0] OUTPUT_STAGE_HOLD_IN,
   input wire logic OUTPUT_STAGE_FULL_IN,
   input wire logic INPUT_STAGE_CLEAR_IN,
   output logic [W-1:0] INPUT_STAGE_OUT,
   output logic INPUT_STAGE_LOAD_OUT,
   output logic EVEN_HALF_RELEASE_OUT,
   output logic ODD_HALF_RELEASE_OUT,
   output logic POINTER_ADVANCE_OUT,
   output logic MIXER_POINTER_OUT,
   output logic IRQ_OUT
);
   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   logic [2:0] ctrl_reg;
   logic [IRQ_W-1:0] mask_reg, irq_reg, irq_set;
   logic ack_reg;
   logic [W-1:0] stage_reg;
   logic full_reg, ptr_reg, dlt_reg, wce_odd_reg, wce_even_reg;
   logic init_pulse, errclr_pulse;
   wire bus_req = WB_CYC_IN && WB_STB_IN && !ack_reg;
   wire bus_wr = bus_req && WB_WE_IN && WB_SEL_IN[0];
   wire wr_ctrl = bus_wr && (WB_ADR_IN == ADDR_CTRL);
   wire wr_irq = bus_wr && (WB_ADR_IN == ADDR_IRQ);
   wire wr_mask = bus_wr && (WB_ADR_IN == ADDR_MASK);
   assign init_pulse = wr_ctrl && WB_DAT_IN[CTRL_INIT];
   assign errclr_pulse = wr_ctrl && WB_DAT_IN[CTRL_ERRCLR];
   wire mode_write = ctrl_reg[CTRL_WRITE];
   wire mode_read = ctrl_reg[CTRL_READ];
   wire mode_wchk = ctrl_reg[CTRL_WCHK];
   wire mode_ready = !(mode_write || mode_read || mode_wchk);
   wire wce_sum = wce_odd_reg || wce_even_reg;
   wire busy;
   logic [31:0] stat_word;
   always_comb begin
      stat_word = 32'h0;
      stat_word[STAT_FULL] = full_reg;
      stat_word[STAT_BUSY] = busy;
      stat_word[STAT_PTR] = ptr_reg;
      stat_word[STAT_DLT] = dlt_reg;
      stat_word[STAT_WCE_EVEN] = wce_even_reg;
      stat_word[STAT_WCE_ODD] = wce_odd_reg;
      stat_word[STAT_WCE_SUM] = wce_sum;
   end
   wire [31:0] rd_word = (WB_ADR_IN == ADDR_CTRL) ? {29'h0, ctrl_reg} :
                         (WB_ADR_IN == ADDR_STAT) ? stat_word :
                         (WB_ADR_IN == ADDR_IRQ) ? {29'h0, irq_reg} :
                         (WB_ADR_IN == ADDR_MASK) ? {29'h0, mask_reg} : 32'h0;
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         ack_reg <= 1'b0;
         WB_DAT_OUT <= 32'h0;
         ctrl_reg <= CTRL_RESET;
         mask_reg <= MASK_RESET;
      end else begin
         ack_reg <= bus_req;
         if (bus_req) begin
            WB_DAT_OUT <= rd_word;
         end
         if (wr_ctrl) begin
            ctrl_reg <= WB_DAT_IN[2:0];
         end
         if (wr_mask) begin
            mask_reg <= WB_DAT_IN[IRQ_W-1:0];
         end
      end
   end
   assign WB_ACK_OUT = ack_reg;
   // ------------------------------------------------------------
   // drive sync clock edge detect
   // ------------------------------------------------------------
   logic sync_meta_reg, sync_reg, sync_last_reg;
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         sync_meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         sync_last_reg <= 1'b0;
      end else begin
         sync_meta_reg <= DRIVE_SYNC_CLK_IN;
         sync_reg <= sync_meta_reg;
         sync_last_reg <= sync_reg;
      end
   end
   // drive data crosses too; the strobe trails sync fall by two edges,
   // so two flops here still catch the word while the drive holds it
   logic [W-1:0] data_meta_reg, data_sync_reg;
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         data_meta_reg <= '0;
         data_sync_reg <= '0;
      end else begin
         data_meta_reg <= DRIVE_DATA_IN;
         data_sync_reg <= data_meta_reg;
      end
   end
   // one-cycle strobe on sync trailing edge
   wire drive_word_strobe = sync_last_reg && !sync_reg;
   // ------------------------------------------------------------
   // mixer word sequence
   // ------------------------------------------------------------
   isl_seq_t seq_reg;
   logic [2:0] tick_reg;
   wire [W-1:0] select_mux_out = ptr_reg ? SELECT_MUX_ODD_IN : SELECT_MUX_EVEN_IN;
   wire half_full = ptr_reg ? ODD_HALF_FULL_IN : EVEN_HALF_FULL_IN;
   wire start_load = half_full && (mode_write || mode_ready) && !full_reg;
   wire start_chk = half_full && OUTPUT_STAGE_FULL_IN && mode_wchk;
   // read or mismatch blocks the sequence
   wire seq_inhibit = mode_read || wce_sum;
   wire seq_start = (seq_reg == ISL_IDLE) && (start_load || start_chk) && !seq_inhibit;
   // strobe window between the two taps
   wire mixer_word_strobe = (seq_reg == ISL_STROBE);
   wire pointer_advance_pulse = (seq_reg == ISL_RELEASE);
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         seq_reg <= ISL_IDLE;
         tick_reg <= 3'h0;
      end else begin
         tick_reg <= tick_reg + 3'h1;
         case (seq_reg)
            ISL_IDLE: begin
               tick_reg <= 3'h1;
               if (seq_start) begin
                  seq_reg <= ISL_WAIT;
               end
            end
            ISL_WAIT: begin
               if (tick_reg == 3'(STROBE_DELAY_CYC)) begin
                  seq_reg <= ISL_STROBE;
               end
            end
            ISL_STROBE: begin
               if (tick_reg == 3'(STROBE_END_CYC)) begin
                  seq_reg <= ISL_RELEASE;
               end
            end
            ISL_RELEASE: begin
               if (tick_reg == 3'(RELEASE_END_CYC)) begin
                  seq_reg <= ISL_IDLE;
               end
            end
            default: seq_reg <= ISL_IDLE;
         endcase
      end
   end
   assign EVEN_HALF_RELEASE_OUT = pointer_advance_pulse && !ptr_reg;
   assign ODD_HALF_RELEASE_OUT = pointer_advance_pulse && ptr_reg;
   assign POINTER_ADVANCE_OUT = pointer_advance_pulse;
   // ------------------------------------------------------------
   // input stage and flags
   // ------------------------------------------------------------
   // load source by mode
   wire mixer_load = mixer_word_strobe && (mode_write || mode_ready);
   wire drive_load = drive_word_strobe && (mode_read || mode_wchk);
   wire input_stage_load = mixer_load || drive_load;
   // busy covers the clear in progress
   assign busy = (mode_read || mode_wchk) && (full_reg || INPUT_STAGE_CLEAR_IN);
   // any differing bit drives the low line
   wire check_mismatch_n = ~|(select_mux_out ^ OUTPUT_STAGE_HOLD_IN);
   wire chk_strobe = mixer_word_strobe && mode_wchk;
   wire adv_end = pointer_advance_pulse && (tick_reg == 3'(RELEASE_END_CYC));
   wire err_clear = errclr_pulse || init_pulse;
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         stage_reg <= '0;
         full_reg <= 1'b0;
         ptr_reg <= 1'b0;
         dlt_reg <= 1'b0;
         wce_odd_reg <= 1'b0;
         wce_even_reg <= 1'b0;
      end else begin
         if (input_stage_load) begin
            stage_reg <= drive_load ? data_sync_reg : select_mux_out;
         end
         if (input_stage_load) begin
            full_reg <= 1'b1;
         end else if (INPUT_STAGE_CLEAR_IN || init_pulse) begin
            full_reg <= 1'b0;
         end
         // toggle as the advance pulse ends
         if (init_pulse) begin
            ptr_reg <= 1'b0;
         end else if (adv_end) begin
            ptr_reg <= !ptr_reg;
         end
         if (drive_word_strobe && busy) begin
            dlt_reg <= 1'b1;
         end else if (err_clear) begin
            dlt_reg <= 1'b0;
         end
         if (chk_strobe && !check_mismatch_n && ptr_reg) begin
            wce_odd_reg <= 1'b1;
         end else if (err_clear) begin
            wce_odd_reg <= 1'b0;
         end
         if (chk_strobe && !check_mismatch_n && !ptr_reg) begin
            wce_even_reg <= 1'b1;
         end else if (err_clear) begin
            wce_even_reg <= 1'b0;
         end
      end
   end
   assign INPUT_STAGE_OUT = stage_reg;
   assign INPUT_STAGE_LOAD_OUT = input_stage_load;
   assign MIXER_POINTER_OUT = ptr_reg;
   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   assign irq_set = {wce_sum, drive_word_strobe && busy, input_stage_load};
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         irq_reg <= '0;
      end else begin
         irq_reg <= irq_set | (irq_reg & ~(wr_irq ? WB_DAT_IN[IRQ_W-1:0] : 3'h0));
      end
   end
   assign IRQ_OUT = |(irq_reg & mask_reg);
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence seq_begin_s;
      seq_start;
   endsequence
   sequence seq_pulses_s;
      // two wait cycles put the strobe in the 100 to 150 ns slot
      !mixer_word_strobe [*2] ##1 mixer_word_strobe ##1 pointer_advance_pulse;
   endsequence
   sequence rel_step_s;
      pointer_advance_pulse ##1 !pointer_advance_pulse;
   endsequence
   strobe_timing_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      seq_begin_s |=> seq_pulses_s) else $error("strobe timing wrong");
   release_gate_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      $rose(pointer_advance_pulse) |-> (ODD_HALF_RELEASE_OUT == ptr_reg) && 
      (EVEN_HALF_RELEASE_OUT == !ptr_reg)) else $error("release mismatch");
   ptr_toggle_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      $fell(pointer_advance_pulse) && !$past(init_pulse) |-> ptr_reg != $past(ptr_reg))
      else $error("pointer did not toggle");
   read_block_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      mode_read |-> !seq_start) else $error("sequence in read");
   freeze_wce_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      wce_sum |-> !seq_start) else $error("sequence after mismatch");
   full_set_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      input_stage_load |=> full_reg) else $error("full not set");
   late_flag_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      drive_word_strobe && busy |=> dlt_reg) else $error("late not flagged");
   wchk_noload_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      mode_wchk && mixer_word_strobe && !drive_word_strobe |-> !input_stage_load)
      else $error("mixer load in write-check");
   odd_latch_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      chk_strobe && !check_mismatch_n && ptr_reg |=> wce_odd_reg && wce_sum)
      else $error("odd mismatch lost");
   even_latch_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      chk_strobe && !check_mismatch_n && !ptr_reg |=> wce_even_reg && wce_sum)
      else $error("even mismatch lost");
   // start guards: a word must wait at the mixer, the stage free where it loads
   write_start_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      seq_start && mode_write |-> half_full && !full_reg)
      else $error("write start without word");
   empty_stage_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      mixer_load |-> !full_reg)
      else $error("mixer load over full stage");
   ready_start_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      seq_start && mode_ready |-> half_full && !full_reg)
      else $error("maintenance start without word");
   chk_start_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      seq_start && mode_wchk |-> half_full && OUTPUT_STAGE_FULL_IN)
      else $error("check start without output word");
   release_end_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      mixer_word_strobe |=> rel_step_s)
      else $error("release not one cycle");
   drive_pulse_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      drive_word_strobe |=> !drive_word_strobe)
      else $error("drive strobe too long");
   mixer_load_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      mixer_word_strobe && (mode_write || mode_ready) |-> input_stage_load)
      else $error("mixer word not loaded");
   drive_load_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      drive_word_strobe && mode_read |-> input_stage_load)
      else $error("drive word not loaded");
   busy_clear_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (mode_read || mode_wchk) && INPUT_STAGE_CLEAR_IN |-> busy)
      else $error("busy missing during clear");
   compare_line_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      select_mux_out != OUTPUT_STAGE_HOLD_IN |-> !check_mismatch_n)
      else $error("mismatch line stayed high");
   full_clear_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      INPUT_STAGE_CLEAR_IN && !input_stage_load |=> !full_reg)
      else $error("full not cleared");
   wce_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      wce_sum && !err_clear |=> wce_sum)
      else $error("mismatch flag lost");
   late_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      dlt_reg && !err_clear |=> dlt_reg)
      else $error("late flag lost");
endmodule

// [hw/isl_pkg.sv]
// constants for the input stage load and write-check block
package isl_pkg;
   localparam int CLK_NS = 50;
   localparam int STROBE_DELAY_NS = 100;
   localparam int STROBE_END_NS = 150;
   localparam int RELEASE_END_NS = 200;
   localparam int DRIVE_PULSE_NS = 50;
   localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_END_CYC = (STROBE_END_NS + CLK_NS - 1) / CLK_NS;
   localparam int RELEASE_END_CYC = (RELEASE_END_NS + CLK_NS - 1) / CLK_NS;
   localparam int DRIVE_PULSE_CYC = DRIVE_PULSE_NS / CLK_NS;
   localparam int DATA_W = 16;
   // register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_IRQ = 4'h8;
   localparam logic [3:0] ADDR_MASK = 4'hc;
   // control bits
   localparam int CTRL_WRITE = 0;
   localparam int CTRL_READ = 1;
   localparam int CTRL_WCHK = 2;
   localparam int CTRL_INIT = 3;
   localparam int CTRL_ERRCLR = 4;
   // status bits
   localparam int STAT_FULL = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_PTR = 2;
   localparam int STAT_DLT = 3;
   localparam int STAT_WCE_EVEN = 4;
   localparam int STAT_WCE_ODD = 5;
   localparam int STAT_WCE_SUM = 14;
   // interrupt bits
   localparam int IRQ_LOAD = 0;
   localparam int IRQ_DLT = 1;
   localparam int IRQ_WCE = 2;
   localparam int IRQ_W = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
   typedef enum logic [1:0] {ISL_IDLE, ISL_WAIT, ISL_STROBE, ISL_RELEASE} isl_seq_t;
endpackage

// [tb/isl_drive_model.sv]
// behavioural drive: one sync clock period per requested word
`timescale 1ns/1ps
module isl_drive_model (
   input wire logic REQ_IN,
   input wire logic [15:0] WORD_IN,
   output logic SYNC_OUT,
   output logic [15:0] DATA_OUT
);
   initial begin
      SYNC_OUT = 1'b0;
      DATA_OUT = 16'h5a5a;
   end
   // sync stands low between words; odd offset keeps its phase apart
   always @(REQ_IN) begin
      DATA_OUT = WORD_IN;
      #113 SYNC_OUT = 1'b1;
      #200 SYNC_OUT = 1'b0;
      #200 DATA_OUT = ~DATA_OUT;
   end
endmodule

// [tb/testbench.sv]
// self-checking bench for the input stage block
`timescale 1ns/1ps
module testbench;
   import isl_pkg::*;
   logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, req = 0;
   logic evf = 0, odf = 0, ofull = 0, sclr = 0, p = 0;
   logic ack, sync, ld, rel_e, rel_o, adv, ptr, irq;
   logic [3:0] adr = 4'h0, sel = 4'hf;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [15:0] mev = 16'h0, mod_ = 16'h0, oh = 16'h0, dw = 16'h0, ddat, stage;
   int num_errors = 0, n_compared = 0, seed = 32'h6e24, i;
   wire [2:0] ev = {adv, ld, irq};
   always #25 clk = ~clk;
   isl_input_stage u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .WB_ADR_IN(adr),
      .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_SEL_IN(sel), .WB_WE_IN(we),
      .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_ACK_OUT(ack), .DRIVE_SYNC_CLK_IN(sync),
      .DRIVE_DATA_IN(ddat), .SELECT_MUX_EVEN_IN(mev), .SELECT_MUX_ODD_IN(mod_),
      .EVEN_HALF_FULL_IN(evf), .ODD_HALF_FULL_IN(odf), .OUTPUT_STAGE_HOLD_IN(oh),
      .OUTPUT_STAGE_FULL_IN(ofull), .INPUT_STAGE_CLEAR_IN(sclr),
      .INPUT_STAGE_OUT(stage), .INPUT_STAGE_LOAD_OUT(ld), .EVEN_HALF_RELEASE_OUT(rel_e),
      .ODD_HALF_RELEASE_OUT(rel_o), .POINTER_ADVANCE_OUT(adv),
      .MIXER_POINTER_OUT(ptr), .IRQ_OUT(irq));
   isl_drive_model u_drv (.REQ_IN(req), .WORD_IN(dw), .SYNC_OUT(sync), .DATA_OUT(ddat));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task give_verdict;
      $display("checks %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task timeout;
      num_errors++;
      give_verdict();
   endtask
   // classic cycle, held until ack is sampled high
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = rdat;
      cyc <= 0;
      stb <= 0;
      if (k >= 20) timeout();
   endtask
   task waitfor(input int e);
      int c;
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (ev[e] !== 1'b1 && c < 100);
      if (c >= 100) timeout();
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      wb(0, ADDR_CTRL, 0);
      chk("ctrl", q, 0);
      wb(0, ADDR_MASK, 0);
      chk("mask", q, 0);
      wb(0, ADDR_STAT, 0);
      chk("status", q, 0);
      wb(0, 4'h1, 0);
      chk("unmapped", q, 0);
      wb(1, ADDR_CTRL, 1);
      {mev, mod_} <= $random(seed);
      evf <= 1;
      odf <= 1;
      // write and maintenance modes alternate between loads
      for (i = 0; i < 6; i++) begin
         waitfor(1);
         #1 chk("stage", stage, p ? mod_ : mev);
         @(posedge clk);
         chk("release", {adv, rel_o, rel_e}, {1'b1, p, ~p});
         p = ~p;
         @(posedge clk);
         chk("pointer", ptr, p);
         repeat (4) @(posedge clk);
         chk("no load", ld, 0);
         wb(0, ADDR_STAT, 0);
         chk("full", q[STAT_FULL], 1);
         {mev, mod_} <= $random(seed);
         wb(1, ADDR_CTRL, {31'h0, i[0]});
         sclr <= 1;
         @(posedge clk);
         sclr <= 0;
      end
      evf <= 0;
      odf <= 0;
      wb(1, ADDR_CTRL, 32'ha);
      wb(0, ADDR_STAT, 0);
      chk("init", q[2:0], 0);
      evf <= 1;
      odf <= 1;
      repeat (10) @(posedge clk);
      chk("read no load", ld, 0);
      dw <= $random(seed);
      req <= ~req;
      waitfor(1);
      #1 chk("drive word", stage, dw);
      @(posedge clk);
      chk("drive pulse", ld, 0);
      wb(0, ADDR_STAT, 0);
      chk("busy", q[1:0], 2'h3);
      repeat (8) @(posedge clk);
      req <= ~req;
      repeat (20) @(posedge clk);
      wb(0, ADDR_IRQ, 0);
      chk("late irq", q[2:0], 3'h3);
      chk("masked", irq, 0);
      wb(1, ADDR_MASK, 32'h2);
      @(posedge clk);
      chk("irq on", irq, 1);
      wb(1, ADDR_IRQ, 32'h2);
      @(posedge clk);
      chk("irq off", irq, 0);
      wb(0, ADDR_STAT, 0);
      chk("late held", q[STAT_DLT], 1);
      wb(1, ADDR_CTRL, 32'h12);
      wb(0, ADDR_STAT, 0);
      chk("late clr", q[STAT_DLT], 0);
      sclr <= 1;
      wb(0, ADDR_STAT, 0);
      chk("busy clear", q[1:0], 2'h2);
      sclr <= 0;
      evf <= 0;
      odf <= 0;
      wb(1, ADDR_CTRL, 32'hc);
      {mev, mod_} <= $random(seed);
      @(posedge clk);
      oh <= mev;
      ofull <= 1;
      evf <= 1;
      odf <= 1;
      waitfor(2);
      oh <= mod_ ^ 16'h0100;
      waitfor(2);
      wb(0, ADDR_STAT, 0);
      chk("wce", {q[STAT_WCE_SUM], q[5:4], q[0]}, 4'hc);
      wb(0, ADDR_IRQ, 0);
      chk("wce irq", q[IRQ_WCE], 1);
      for (i = 0; i < 12; i++) begin
         @(posedge clk);
         chk("frozen", adv, 0);
      end
      ofull <= 0;
      wb(1, ADDR_CTRL, 32'h14);
      wb(0, ADDR_STAT, 0);
      chk("wce clr", {q[STAT_WCE_SUM], q[5:4]}, 0);
      // even word mismatch after the clear
      oh <= ~mev;
      ofull <= 1;
      waitfor(2);
      wb(0, ADDR_STAT, 0);
      chk("even wce", {q[STAT_WCE_SUM], q[5:4]}, 3'h5);
      give_verdict();
   end
endmodule
